// ---- logic/led_sink_pkg.sv ----
// Function
// - sink a enable bit sits at bit 0 of the power enable register, resets 0
// - sink b enable bit sits at bit 1 of the same register, resets 0
// - bit 12 of each driver register keeps the sink on in sleep when set
// - bit 15 of each driver register aliases that sink's single enable bit
// - bits 5 to 0 of each driver register hold an unsigned current code
// - current code maps logarithmically, doubling every four codes from 4.05 uA
// - the two current codes are separate; writing one leaves the other alone
// - only the two constant current sinks carry enable and sleep bits
// - a sink drives current only while its enable bit is set
package led_sink_pkg;

   // ***************************************************************
   // register map
   // ***************************************************************
   localparam logic [7:0]  POWER_ENABLES_OFS = 8'h0E;
   localparam logic [7:0]  SINK_A_CTRL_OFS   = 8'hAC;
   localparam logic [7:0]  SINK_B_CTRL_OFS   = 8'hAE;
   localparam logic [7:0]  SINK_STATUS_OFS   = 8'hB8;

   // ***************************************************************
   // field positions and reset values
   // ***************************************************************
   localparam int          EN_A_BIT          = 0;
   localparam int          EN_B_BIT          = 1;
   localparam int          CTRL_EN_BIT       = 15;
   localparam int          CTRL_KEEP_BIT     = 12;
   localparam int          CODE_MSB          = 5;
   localparam int          CODE_W            = 6;
   localparam logic [5:0]  CODE_RESET        = 6'h00;
   localparam int          STAT_A_ON_BIT     = 0;
   localparam int          STAT_B_ON_BIT     = 1;
   localparam int          STAT_SLEEP_BIT    = 2;
   localparam int          STAT_SLEEP_AGE_LSB = 8;
   localparam logic [15:0] UNMAPPED_READ     = 16'h0000;

   // ***************************************************************
   // current scale: 4.05 uA at code 0, doubling every 4 codes
   // ***************************************************************
   localparam int          BASE_NA           = 4050;
   localparam int          CODES_PER_DOUBLE  = 4;

   typedef struct packed {
      logic       enable;
      logic       sleep_keep;
      logic [5:0] current_code;
   } sink_cfg_t;

   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

endpackage

// ---- logic/sink_channel.sv ----
`timescale 1ns/1ps
module sink_channel
   import led_sink_pkg::*;
(
   // clock and reset
   input  wire logic                   mclk,
   input  wire logic                   rst,
   // settings and sleep state
   input  wire led_sink_pkg::sink_cfg_t cfg,
   input  wire logic                   sleep,
   // analog drive
   output logic                        drive_on,
   output logic [5:0]                  drive_code
);
   import led_sink_pkg::*;

   always_ff @(posedge mclk) begin
      if (rst) begin
         drive_on <= 1'b0;
      end else begin
         drive_on <= cfg.enable & (~sleep | cfg.sleep_keep);
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         drive_code <= CODE_RESET;
      end else begin
         drive_code <= cfg.current_code;
      end
   end
endmodule // sink_channel

// ---- logic/reg_reader.sv ----
`timescale 1ns/1ps
module reg_reader
   import led_sink_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // read request and mapped word
   input  wire logic        rd,
   input  wire logic [15:0] word,
   // registered read data
   output logic [15:0]      rdata
);
   import led_sink_pkg::*;

   // data stands one cycle after the strobe and only there
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata <= UNMAPPED_READ;
      end else if (rd) begin
         rdata <= word;
      end else begin
         rdata <= UNMAPPED_READ;
      end
   end
endmodule // reg_reader

// ---- logic/led_current_sink_control.sv ----
`timescale 1ns/1ps
module led_current_sink_control
   import led_sink_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // register port
   input  wire logic [7:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [15:0]      rdata,
   // power state
   input  wire logic        sleep,
   // sink drive
   output logic             sink_a_pin,
   output logic [5:0]       sink_a_current,
   output logic             sink_b_pin,
   output logic [5:0]       sink_b_current
);
   import led_sink_pkg::*;

   // ***************************************************************
   // stored settings
   // ***************************************************************
   logic       sink_a_enable_reg;
   logic       sink_b_enable_reg;
   logic       sink_a_sleep_keep_reg;
   logic       sink_b_sleep_keep_reg;
   logic [5:0] sink_a_current_code_reg;
   logic [5:0] sink_b_current_code_reg;
   logic [7:0] sleep_age_reg;
   logic [15:0] read_word;
   sink_cfg_t  cfg_a;
   sink_cfg_t  cfg_b;

   // ***************************************************************
   // enable bits, one store reached at two addresses
   // ***************************************************************
   always_ff @(posedge mclk) begin
      if (rst) begin
         sink_a_enable_reg <= 1'b0;
         sink_b_enable_reg <= 1'b0;
      end else if (wr) begin
         if (addr == POWER_ENABLES_OFS) begin
            sink_a_enable_reg <= wdata[EN_A_BIT];
            sink_b_enable_reg <= wdata[EN_B_BIT];
         end else if (addr == SINK_A_CTRL_OFS) begin
            sink_a_enable_reg <= wdata[CTRL_EN_BIT];
         end else if (addr == SINK_B_CTRL_OFS) begin
            sink_b_enable_reg <= wdata[CTRL_EN_BIT];
         end
      end
   end

   // ***************************************************************
   // sleep keep and current code, one register per sink
   // ***************************************************************
   always_ff @(posedge mclk) begin
      if (rst) begin
         sink_a_sleep_keep_reg   <= 1'b0;
         sink_a_current_code_reg <= CODE_RESET;
      end else if (wr && addr == SINK_A_CTRL_OFS) begin
         sink_a_sleep_keep_reg   <= wdata[CTRL_KEEP_BIT];
         sink_a_current_code_reg <= wdata[CODE_MSB:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         sink_b_sleep_keep_reg   <= 1'b0;
         sink_b_current_code_reg <= CODE_RESET;
      end else if (wr && addr == SINK_B_CTRL_OFS) begin
         sink_b_sleep_keep_reg   <= wdata[CTRL_KEEP_BIT];
         sink_b_current_code_reg <= wdata[CODE_MSB:0];
      end
   end

   // saturating count of cycles spent asleep, for software to observe
   always_ff @(posedge mclk) begin
      if (rst) begin
         sleep_age_reg <= 8'h00;
      end else if (!sleep) begin
         sleep_age_reg <= 8'h00;
      end else if (sleep_age_reg != 8'hFF) begin
         sleep_age_reg <= sleep_age_reg + 8'h01;
      end
   end

   // ***************************************************************
   // read mux
   // ***************************************************************
   always_comb begin
      read_word = UNMAPPED_READ;
      unique case (addr)
         POWER_ENABLES_OFS: begin
            read_word[EN_A_BIT] = sink_a_enable_reg;
            read_word[EN_B_BIT] = sink_b_enable_reg;
         end
         SINK_A_CTRL_OFS: begin
            read_word[CTRL_EN_BIT]   = sink_a_enable_reg;
            read_word[CTRL_KEEP_BIT] = sink_a_sleep_keep_reg;
            read_word[CODE_MSB:0]    = sink_a_current_code_reg;
         end
         SINK_B_CTRL_OFS: begin
            read_word[CTRL_EN_BIT]   = sink_b_enable_reg;
            read_word[CTRL_KEEP_BIT] = sink_b_sleep_keep_reg;
            read_word[CODE_MSB:0]    = sink_b_current_code_reg;
         end
         SINK_STATUS_OFS: begin
            read_word[STAT_A_ON_BIT]  = sink_a_pin;
            read_word[STAT_B_ON_BIT]  = sink_b_pin;
            read_word[STAT_SLEEP_BIT] = sleep;
            read_word[STAT_SLEEP_AGE_LSB +: 8] = sleep_age_reg;
         end
         default: begin
            read_word = UNMAPPED_READ;
         end
      endcase
   end

   reg_reader u_reader (
      .mclk  (mclk),
      .rst   (rst),
      .rd    (rd),
      .word  (read_word),
      .rdata (rdata)
   );

   // ***************************************************************
   // sink drive; no control exists for the open-drain leds
   // ***************************************************************
   // two sinks only
   assign cfg_a = '{enable: sink_a_enable_reg, sleep_keep: sink_a_sleep_keep_reg,
                    current_code: sink_a_current_code_reg};
   assign cfg_b = '{enable: sink_b_enable_reg, sleep_keep: sink_b_sleep_keep_reg,
                    current_code: sink_b_current_code_reg};

   sink_channel u_sink_a (
      .mclk       (mclk),
      .rst        (rst),
      .cfg        (cfg_a),
      .sleep      (sleep),
      .drive_on   (sink_a_pin),
      .drive_code (sink_a_current)
   );

   sink_channel u_sink_b (
      .mclk       (mclk),
      .rst        (rst),
      .cfg        (cfg_b),
      .sleep      (sleep),
      .drive_on   (sink_b_pin),
      .drive_code (sink_b_current)
   );
endmodule // led_current_sink_control

// ---- verif/led_current_sink_control_assertions.sv ----
`timescale 1ns/1ps
module led_current_sink_control_assertions (
   // clock and reset
   input wire logic        mclk,
   input wire logic        rst,
   // register port
   input wire logic [7:0]  addr,
   input wire logic [15:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [15:0] rdata,
   // power state and drive
   input wire logic        sleep,
   input wire logic        sink_a_pin,
   input wire logic [5:0]  sink_a_current,
   input wire logic        sink_b_pin,
   input wire logic [5:0]  sink_b_current
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   property p_rd_idle; !rd |=> rdata == 16'h0000; endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data not idle");
   property p_code_a; wr && addr == 8'hAC |-> ##2 sink_a_current == $past(wdata[5:0], 2);
   endproperty
   a_code_a: assert property (p_code_a)
      else $error("sink a code wrong");
   property p_code_b_kept; wr && addr == 8'hAC |-> ##2 $stable(sink_b_current); endproperty
   a_code_b_kept: assert property (p_code_b_kept)
      else $error("sink b code disturbed");
   property p_en_a; wr && addr == 8'h0E ##1 !sleep |=> sink_a_pin == $past(wdata[0], 2);
   endproperty
   a_en_a: assert property (p_en_a)
      else $error("sink a enable wrong");
   property p_alias_a; wr && addr == 8'hAC ##1 !sleep |=> sink_a_pin == $past(wdata[15], 2);
   endproperty
   a_alias_a: assert property (p_alias_a)
      else $error("sink a alias wrong");
   property p_sleep_a; rd && addr == 8'hAC ##1 (sleep && rdata[15]) |=>
      sink_a_pin == $past(rdata[12]); endproperty
   a_sleep_a: assert property (p_sleep_a)
      else $error("sink a sleep drive wrong");
   property p_active_a; rd && addr == 8'h0E ##1 !sleep |=> sink_a_pin == $past(rdata[0]);
   endproperty
   a_active_a: assert property (p_active_a)
      else $error("sink a drive not enable");
   property p_reserved; rd && addr == 8'h0E |=> rdata[15:2] == 14'h0000; endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved enable bits set");
endmodule // led_current_sink_control_assertions

bind led_current_sink_control led_current_sink_control_assertions chk_i (.mclk(mclk),
   .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sleep(sleep),
   .sink_a_pin(sink_a_pin), .sink_a_current(sink_a_current), .sink_b_pin(sink_b_pin),
   .sink_b_current(sink_b_current));

// ---- verif/led_current_sink_control_bench.sv ----
`timescale 1ns/1ps
module led_current_sink_control_bench;
   import led_sink_pkg::*;
   logic        mclk, rst, wr, rd, sleep, pa, pb;
   logic [7:0]  addr;
   logic [15:0] wdata, rdata;
   logic [5:0]  ca, cb;
   int          fail_count, checks_done;
   led_current_sink_control uut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .sleep(sleep), .sink_a_pin(pa),
      .sink_a_current(ca), .sink_b_pin(pb), .sink_b_current(cb));
   initial begin
      mclk = 1'h0;
      forever #5 mclk = ~mclk;
   end
   task automatic chk(string n, logic [15:0] e, logic [15:0] s);
      checks_done++;
      if (s !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wreg(logic [7:0] a, logic [15:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge mclk);
      wr <= 1'h0;
   endtask
   task automatic rreg(logic [7:0] a, logic [15:0] e);
      @(posedge mclk);
      addr <= a;
      rd <= 1'h1;
      @(posedge mclk);
      rd <= 1'h0;
      #1 chk("rdata", e, rdata);
   endtask
   // drive outputs settle two edges after a change; order a_on, a_code, b_on, b_code
   task automatic cdrive(logic [13:0] e);
      repeat (3) @(posedge mclk);
      #1 chk("drive", {2'h0, e}, {2'h0, pa, ca, pb, cb});
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // *********************************************
   // tests
   // *********************************************
   initial begin
      rst <= 1'h1;
      wr <= 1'h0;
      rd <= 1'h0;
      sleep <= 1'h0;
      addr <= 8'h00;
      wdata <= 16'h0000;
      repeat (20) @(posedge mclk);
      rst <= 1'h0;
      rreg(POWER_ENABLES_OFS, 16'h0000);
      rreg(SINK_A_CTRL_OFS, 16'h0000);
      rreg(SINK_B_CTRL_OFS, 16'h0000);
      cdrive(14'h0000);
      $display("test reset done");
      // sinks come on first, through the power enable register
      wreg(POWER_ENABLES_OFS, 16'hFFFF);
      rreg(POWER_ENABLES_OFS, 16'h0003);
      rreg(SINK_A_CTRL_OFS, 16'h8000);
      rreg(SINK_B_CTRL_OFS, 16'h8000);
      cdrive({1'h1, 6'h00, 1'h1, 6'h00});
      wreg(SINK_A_CTRL_OFS, 16'h1015);
      // code 35 is the highest one at or under 40 mA for continuous use
      wreg(SINK_B_CTRL_OFS, 16'h8035);
      rreg(POWER_ENABLES_OFS, 16'h0002);
      cdrive({1'h0, 6'h15, 1'h1, 6'h35});
      $display("test enables done");
      wreg(SINK_A_CTRL_OFS, 16'h9005);
      wreg(SINK_B_CTRL_OFS, 16'h8003);
      sleep <= 1'h1;
      cdrive({1'h1, 6'h05, 1'h0, 6'h03});
      rreg(SINK_A_CTRL_OFS, 16'h9005);
      rreg(SINK_B_CTRL_OFS, 16'h8003);
      // long enough for the sleep age to saturate
      repeat (260) @(posedge mclk);
      rreg(SINK_STATUS_OFS, 16'hFF05);
      sleep <= 1'h0;
      cdrive({1'h1, 6'h05, 1'h1, 6'h03});
      rreg(SINK_STATUS_OFS, 16'h0003);
      $display("test sleep done");
      wreg(8'h40, 16'hFFFF);
      rreg(8'h40, 16'h0000);
      wreg(POWER_ENABLES_OFS, 16'h0000);
      rreg(SINK_A_CTRL_OFS, 16'h1005);
      cdrive({1'h0, 6'h05, 1'h0, 6'h03});
      $display("test unmapped and disable done");
      results;
   end
   // whole sequence takes about three hundred forty cycles, most of it the sleep wait
   initial begin
      repeat (1000) @(posedge mclk);
      fail_count++;
      results;
   end
endmodule // led_current_sink_control_bench
